// *** iec_top.sv ***
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`include "iec_defines.svh"

// Overview of operation
// - Occurring events set their new-event bits
// - Writing one sets a new-event bit
// - Any main event write clears new-events
// - Interrupt status read clears new-events
// - Soft reset holds new-events cleared
// - Fields numbered from top; reserved read zero
// - Enable bit one lets status reach the interrupt
// - Enable resets to 0x74de5f3f
// - Defined enables read/write; reserved read zero
// - Defined enable bits reset one except bits 25:24, read/write
module iec_top
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [19:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // Event sources and controls
  input wire logic [31:0] events_i,
  input wire logic soft_reset_ctl_i,
  input wire logic int_status_read_i,
  // Interrupt
  output logic [31:0] int_contrib_o,
  output logic irq_o
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  iec_regbus_if rb ();

  iec_apb_slave u_apb
  (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pready_o(pready_o),
    .prdata_o(prdata_o),
    .pslverr_o(pslverr_o),
    .rb(rb.slave)
  );

  // ****************************************************************
  // Event registers
  // ****************************************************************
  logic [31:0] new_event_capture;
  logic [31:0] event_interrupt_enable;
  logic [31:0] event_status;
  logic [31:0] next_new_event_capture;
  logic [31:0] next_event_interrupt_enable;
  logic [31:0] next_event_status;
  logic [31:0] ev;
  logic wr_new;
  logic wr_enable;
  logic wr_status;

  // Reserved event lines are dropped at the door
  assign ev = events_i & `IEC_DEFINED_MASK;
  assign wr_new = rb.wr_strobe & (rb.sel == iec_pkg::IEC_SEL_NEW_EVENT);
  assign wr_enable = rb.wr_strobe & (rb.sel == iec_pkg::IEC_SEL_ENABLE);
  assign wr_status = rb.wr_strobe & (rb.sel == iec_pkg::IEC_SEL_STATUS);

  // New events: clear first, then sets on top so nothing is lost
  always_comb
  begin
    next_new_event_capture = new_event_capture;
    if (wr_status | int_status_read_i)
    begin
      next_new_event_capture = `IEC_ZERO_WORD;
    end
    next_new_event_capture = next_new_event_capture | ev;
    if (wr_new)
    begin
      next_new_event_capture = next_new_event_capture | rb.wdata;
    end
    next_new_event_capture = next_new_event_capture & `IEC_DEFINED_MASK;
    // Soft reset overrides everything, including fresh events
    if (soft_reset_ctl_i)
    begin
      next_new_event_capture = `IEC_ZERO_WORD;
    end
  end

  // Enables: plain read/write on defined positions only
  always_comb
  begin
    next_event_interrupt_enable = event_interrupt_enable;
    if (wr_enable)
    begin
      next_event_interrupt_enable = rb.wdata & `IEC_DEFINED_MASK;
    end
  end

  // Main event status: sticky, write one to clear, set wins
  always_comb
  begin
    next_event_status = event_status;
    if (wr_status)
    begin
      next_event_status = event_status & ~rb.wdata;
    end
    next_event_status = (next_event_status | ev) & `IEC_DEFINED_MASK;
  end

  // State registers
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      new_event_capture <= `IEC_NEW_EVENT_RST;
      event_interrupt_enable <= `IEC_EVENT_ENABLE_RST;
      event_status <= `IEC_EVENT_STATUS_RST;
    end
    else
    begin
      new_event_capture <= next_new_event_capture;
      event_interrupt_enable <= next_event_interrupt_enable;
      event_status <= next_event_status;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    case (rb.sel)
      iec_pkg::IEC_SEL_NEW_EVENT: rb.rdata = new_event_capture;
      iec_pkg::IEC_SEL_ENABLE: rb.rdata = event_interrupt_enable;
      iec_pkg::IEC_SEL_STATUS: rb.rdata = event_status;
      default: rb.rdata = `IEC_ZERO_WORD;
    endcase
  end

  // ****************************************************************
  // Interrupt
  // ****************************************************************
  iec_irq_gen u_irq
  (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .status_i(event_status),
    .enable_i(event_interrupt_enable),
    .contrib_o(int_contrib_o),
    .irq_o(irq_o)
  );

endmodule

// *** iec_defines.svh ***
`ifndef IEC_DEFINES_SVH
`define IEC_DEFINES_SVH

// ****************************************************************
// Register map (byte addresses on the APB)
// ****************************************************************
`define IEC_ADDR_W 20
`define IEC_NEW_EVENT_OFF 20'h1d308
`define IEC_EVENT_ENABLE_OFF 20'h1d30c
`define IEC_EVENT_STATUS_OFF 20'h1d380

// ****************************************************************
// Field layout and reset values
// ****************************************************************
// Field layout is numbered from the top, so position n sits at bit 31-n
`define IEC_DEFINED_MASK 32'h77de5f3f
`define IEC_NEW_EVENT_RST 32'h00000000
`define IEC_EVENT_ENABLE_RST 32'h74de5f3f
`define IEC_EVENT_STATUS_RST 32'h00000000
`define IEC_ZERO_WORD 32'h00000000

`endif

// *** iec_pkg.sv ***
package iec_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [31:0] iec_word_t;
  typedef logic [19:0] iec_addr_t;

  // Register selected by an APB address
  typedef enum logic [3:0]
  {
    IEC_SEL_NONE = 4'h1,
    IEC_SEL_NEW_EVENT = 4'h2,
    IEC_SEL_ENABLE = 4'h4,
    IEC_SEL_STATUS = 4'h8
  } iec_sel_e;

  // APB slave handshake states
  typedef enum logic [1:0]
  {
    IEC_BUS_IDLE = 2'h1,
    IEC_BUS_ANSWER = 2'h2
  } iec_bus_state_e;

endpackage

// *** iec_regbus_if.sv ***
`timescale 1ns/10ps

// Committed register access between the bus slave and the register bank
interface iec_regbus_if;
  logic wr_strobe;
  iec_pkg::iec_sel_e sel;
  iec_pkg::iec_word_t wdata;
  iec_pkg::iec_word_t rdata;

  modport slave
  (
    output wr_strobe,
    output sel,
    output wdata,
    input rdata
  );

  modport bank
  (
    input wr_strobe,
    input sel,
    input wdata,
    output rdata
  );
endinterface

// *** iec_apb_slave.sv ***
`timescale 1ns/10ps
`include "iec_defines.svh"

module iec_apb_slave
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [19:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // Register bank side
  iec_regbus_if.slave rb
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic iec_pkg::iec_sel_e decode(input logic [19:0] addr);
    case (addr)
      `IEC_NEW_EVENT_OFF: decode = iec_pkg::IEC_SEL_NEW_EVENT;
      `IEC_EVENT_ENABLE_OFF: decode = iec_pkg::IEC_SEL_ENABLE;
      `IEC_EVENT_STATUS_OFF: decode = iec_pkg::IEC_SEL_STATUS;
      default: decode = iec_pkg::IEC_SEL_NONE;
    endcase
  endfunction

  iec_pkg::iec_bus_state_e state;
  iec_pkg::iec_bus_state_e next_state;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic access;

  // Commit only on the edge where pready is seen high
  assign access = psel_i & penable_i & pready_o;
  assign rb.wr_strobe = access & pwrite_i;
  assign rb.sel = decode(paddr_i);
  assign rb.wdata = pwdata_i;

  // One wait state: read data is captured on the edge where pready rises
  always_comb
  begin
    next_state = state;
    next_prdata = prdata_o;
    next_pslverr = pslverr_o;
    case (state)
      iec_pkg::IEC_BUS_IDLE:
      begin
        if (psel_i & penable_i)
        begin
          next_state = iec_pkg::IEC_BUS_ANSWER;
          next_prdata = pwrite_i ? `IEC_ZERO_WORD : rb.rdata;
          next_pslverr = (decode(paddr_i) == iec_pkg::IEC_SEL_NONE);
        end
      end
      iec_pkg::IEC_BUS_ANSWER:
      begin
        next_state = iec_pkg::IEC_BUS_IDLE;
        next_prdata = `IEC_ZERO_WORD;
        next_pslverr = 1'b0;
      end
      default:
      begin
        next_state = iec_pkg::IEC_BUS_IDLE;
      end
    endcase
  end

  // Handshake registers
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= iec_pkg::IEC_BUS_IDLE;
      pready_o <= 1'b0;
      prdata_o <= `IEC_ZERO_WORD;
      pslverr_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      // Ready has its own flop so the pin never sees decode glitches
      pready_o <= (next_state == iec_pkg::IEC_BUS_ANSWER);
      prdata_o <= next_prdata;
      pslverr_o <= next_pslverr;
    end
  end

endmodule

// *** iec_irq_gen.sv ***
`timescale 1ns/10ps
`include "iec_defines.svh"

module iec_irq_gen
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Event status and enables
  input wire logic [31:0] status_i,
  input wire logic [31:0] enable_i,
  // Results
  output logic [31:0] contrib_o,
  output logic irq_o
);

  logic [31:0] next_contrib;
  logic next_irq;

  // Per event gating; reserved positions never contribute
  always_comb
  begin
    next_contrib = status_i & enable_i & `IEC_DEFINED_MASK;
    next_irq = |next_contrib;
  end

  // Registered so the outputs are glitch free
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      contrib_o <= `IEC_ZERO_WORD;
      irq_o <= 1'b0;
    end
    else
    begin
      contrib_o <= next_contrib;
      irq_o <= next_irq;
    end
  end

endmodule

// *** iec_top_props.sv ***
`timescale 1ns/10ps
`include "iec_defines.svh"

// ****
// Port checker
// ****
module iec_top_props
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Watched ports
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [19:0] paddr_i,
  input wire logic soft_reset_ctl_i,
  input wire logic pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  input wire logic [31:0] int_contrib_o,
  input wire logic irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // Decode kept apart so a wrong map shows
  logic hit;
  assign hit = paddr_i inside {20'h1d308, 20'h1d30c, 20'h1d380};
  a_ready_late: assert property ($rose(penable_i) && psel_i |=> pready_o)
    else $error("ready late");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  a_ready_phase: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access");
  a_data_idle: assert property (!pready_o |-> prdata_o == 0)
    else $error("read data not idle");
  a_err_decode: assert property (pready_o |-> pslverr_o == !hit)
    else $error("error decode wrong");
  a_resv_zero: assert property (pready_o && !pwrite_i |->
    (prdata_o & ~`IEC_DEFINED_MASK) == 0)
    else $error("reserved bit read one");
  a_contrib_mask: assert property ((int_contrib_o & ~`IEC_DEFINED_MASK) == 0)
    else $error("reserved contribution");
  a_irq_or: assert property (irq_o == |int_contrib_o)
    else $error("irq not OR");
  a_soft_hold: assert property (pready_o && !pwrite_i && paddr_i == 20'h1d308
    && $past(soft_reset_ctl_i, 2) |-> prdata_o == 0)
    else $error("event under soft reset");
  c_err: cover property (pready_o && pslverr_o);
  c_irq: cover property ($rose(irq_o));
  c_read: cover property (pready_o && !pwrite_i && prdata_o != 0);
endmodule

bind iec_top iec_top_props iec_top_props_i (.clock_i, .arst_n_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .soft_reset_ctl_i, .pready_o, .prdata_o, .pslverr_o,
  .int_contrib_o, .irq_o);

// *** iec_top_test.sv ***
`timescale 1ns/10ps

// ****
// Self-checking bench
// ****
module iec_top_test;
  logic clock_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [19:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, events_i = 0, prdata_o, int_contrib_o, rd;
  logic soft_reset_ctl_i = 0, int_status_read_i = 0, pready_o, pslverr_o, irq_o, er;
  int err_total = 0, checks_done = 0, cyc = 0;
  localparam logic [19:0] NE = 20'h1d308, EN = 20'h1d30c, ST = 20'h1d380;

  iec_top iec_top_i (.clock_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .events_i, .soft_reset_ctl_i,
    .int_status_read_i, .int_contrib_o, .irq_o);

  // Clock and hang guard
  always #2 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      finish_test();
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask

  task finish_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One APB transfer; waits on pready, never on a fixed count
  task apb(input logic w, input logic [19:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1;
    // Look mid-cycle so the answer is settled, then release after its edge
    do @(negedge clock_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    @(posedge clock_i);
    psel_i <= 0;
    penable_i <= 0;
  endtask

  task rdc(input logic [19:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
  endtask

  // Event held for exactly one edge
  task ev(input logic [31:0] x, input logic snap);
    @(posedge clock_i);
    events_i <= x;
    int_status_read_i <= snap;
    @(posedge clock_i);
    events_i <= 0;
    int_status_read_i <= 0;
  endtask

  task t_regs;
    rdc(EN, 32'h74de5f3f);
    rdc(NE, 0);
    apb(0, 20'h1d3f0, 0);
    chk(er, 1);
    apb(1, EN, 32'hffffffff);
    rdc(EN, 32'h77de5f3f);
  endtask

  task t_new;
    apb(1, NE, 32'hffffffff);
    rdc(NE, 32'h77de5f3f);
    apb(1, NE, 0);
    rdc(NE, 32'h77de5f3f);
    apb(1, ST, 0);
    rdc(NE, 0);
    ev(32'h40000001, 0);
    rdc(NE, 32'h40000001);
    ev(32'h00000100, 1);
    rdc(NE, 32'h00000100);
    ev(0, 1);
    rdc(NE, 0);
  endtask

  task t_soft;
    soft_reset_ctl_i <= 1;
    ev(32'hffffffff, 0);
    apb(1, NE, 32'hffffffff);
    rdc(NE, 0);
    soft_reset_ctl_i <= 0;
    rdc(NE, 0);
  endtask

  // Masked event, then unmasked, then cleared by a one
  task t_irq;
    apb(1, EN, 0);
    apb(1, ST, 32'hffffffff);
    ev(32'h00004000, 0);
    rdc(ST, 32'h00004000);
    repeat (3) @(posedge clock_i);
    chk(irq_o, 0);
    apb(1, EN, 32'h00004000);
    repeat (2) @(posedge clock_i);
    chk(int_contrib_o, 32'h00004000);
    chk(irq_o, 1);
    apb(1, ST, 32'h00004000);
    repeat (2) @(posedge clock_i);
    chk(irq_o, 0);
    rdc(ST, 0);
  endtask

  initial
  begin
    repeat (3) @(posedge clock_i);
    arst_n_i <= 1;
    t_regs();
    t_new();
    t_soft();
    t_irq();
    finish_test();
  end
endmodule
